// file: hw/cfg_bank_pkg.sv
`default_nettype none
package cfg_bank_pkg;

   // register addresses (documented offsets, 8-bit address space)
   localparam logic [7:0] ADDR_PIN_SETUP_B        = 8'hA6;
   localparam logic [7:0] ADDR_DEVICE_SETUP       = 8'hA8;
   localparam logic [7:0] ADDR_DRIVER_SETUP_A     = 8'hAC;
   localparam logic [7:0] ADDR_DRIVER_SETUP_B     = 8'hAE;
   localparam logic [7:0] ADDR_BRIDGE_FAULT_FLAGS = 8'hE0;
   localparam logic [7:0] ADDR_CONTROL_FAULT_FLAGS = 8'hE2;

   // reset values
   localparam logic [31:0] RST_PIN_SETUP_B    = 32'h00000000;
   localparam logic [31:0] RST_DEVICE_SETUP   = 32'h00000000;
   localparam logic [31:0] RST_DRIVER_SETUP_A = 32'h00228000;
   localparam logic [31:0] RST_DRIVER_SETUP_B = 32'h01200000;

   // writable masks: reserved bits keep their reset value
   localparam logic [31:0] WMASK_PIN_SETUP_B    = 32'h8001E000;
   localparam logic [31:0] WMASK_DEVICE_SETUP   = 32'hFFFFCF78;
   localparam logic [31:0] WMASK_DRIVER_SETUP_A = 32'h8C0D3F3F;
   localparam logic [31:0] WMASK_DRIVER_SETUP_B = 32'hFFF00000;

   // common field position
   localparam int PARITY_BIT = 31;

   // pin_setup_b fields
   localparam int KICK_SRC_BIT  = 16;
   localparam int KICK_MISS_BIT = 15;
   localparam int KICK_RATE_LSB = 13;

   // device_setup fields
   localparam int MAX_FREQ_LSB   = 16;
   localparam int SELF_TEST_BIT  = 15;
   localparam int SSM_OFF_BIT    = 14;
   localparam int LOW_PWR_BIT    = 11;
   localparam int PWM_BAND_BIT   = 10;
   localparam int CLK_SRC_LSB    = 8;
   localparam int OCLK_ON_BIT    = 6;
   localparam int OCLK_RATE_LSB  = 3;

   // driver_setup_a fields
   localparam int SLEW_LSB       = 26;
   localparam int OV_LEVEL_BIT   = 19;
   localparam int OV_ON_BIT      = 18;
   localparam int HEAT_PIN_BIT   = 16;
   localparam int OC_FILT_LSB    = 12;
   localparam int OC_WAIT_BIT    = 11;
   localparam int OC_LEVEL_BIT   = 10;
   localparam int OC_RESP_LSB    = 8;
   localparam int DEMAG_LO_BIT   = 5;
   localparam int DEMAG_HI_BIT   = 4;
   localparam int SYNC_RECT_BIT  = 3;
   localparam int ASYNC_RECT_BIT = 2;
   localparam int GAIN_LSB       = 0;

   // driver_setup_b fields
   localparam int DCOMP_ON_BIT   = 30;
   localparam int DCOMP_TGT_LSB  = 26;
   localparam int REG_EDGE_BIT   = 25;
   localparam int REG_SEQ_BIT    = 24;
   localparam int REG_CAP_BIT    = 23;
   localparam int REG_VOLT_LSB   = 21;
   localparam int REG_OFF_BIT    = 20;

   // encodings
   localparam logic [1:0] CLK_SRC_INTERNAL = 2'h0;
   localparam logic [1:0] CLK_SRC_OUTSIDE  = 2'h3;

   // overcurrent response codes
   typedef enum logic [1:0] {
      OC_LATCH  = 2'b00,
      OC_RETRY  = 2'b01,
      OC_REPORT = 2'b10,
      OC_IGNORE = 2'b11
   } oc_resp_t;

   // host register request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } reg_req_t;

   // watchdog controls
   typedef struct packed {
      logic       src_gpio;
      logic       miss_latch;
      logic [1:0] rate;
   } kick_cfg_t;

   // device controls
   typedef struct packed {
      logic [14:0] max_freq_hz;
      logic        self_test_on;
      logic        spread_on;
      logic        sleep_sel;
      logic        pwm_low_band;
      logic        use_outside_clk;
      logic        clk_sel_bad;
      logic [2:0]  outside_clock_rate;
   } dev_cfg_t;

   // gate driver and regulator controls
   typedef struct packed {
      logic [1:0] slew;
      logic       ov_guard;
      logic       ov_20v;
      logic       heat_warning_to_pin;
      logic [1:0] oc_filter;
      logic       oc_wait_long;
      logic       oc_level_high;
      oc_resp_t   oc_resp;
      logic       demag_low_threshold;
      logic       demag_high_threshold;
      logic       sync_rectify_on;
      logic       async_rectify_on;
      logic [1:0] sense_amp_gain;
      logic       dcomp_on;
      logic       dcomp_auto;
      logic [3:0] dcomp_target;
      logic       regulator_edge_speed;
      logic       regulator_sequencing_off;
      logic       regulator_current_cap;
      logic [1:0] regulator_volt;
      logic       regulator_on;
   } drv_cfg_t;

endpackage : cfg_bank_pkg
`default_nettype wire

// file: hw/cfg_field_decode.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_field_decode
   import cfg_bank_pkg::*;
(
   // stored register images
   input  wire logic [31:0]             i_pin_b,
   input  wire logic [31:0]             i_dev,
   input  wire logic [31:0]             i_drv_a,
   input  wire logic [31:0]             i_drv_b,
   // decoded controls
   output var  cfg_bank_pkg::kick_cfg_t o_kick,
   output var  cfg_bank_pkg::dev_cfg_t  o_dev,
   output var  cfg_bank_pkg::drv_cfg_t  o_drv
);
   // watchdog source, miss response and rate
   assign o_kick.src_gpio   = i_pin_b[KICK_SRC_BIT];
   assign o_kick.miss_latch = i_pin_b[KICK_MISS_BIT];
   assign o_kick.rate       = i_pin_b[KICK_RATE_LSB +: 2];

   // device configuration
   assign o_dev.max_freq_hz     = i_dev[MAX_FREQ_LSB +: 15];
   assign o_dev.self_test_on    = i_dev[SELF_TEST_BIT];
   assign o_dev.spread_on       = ~i_dev[SSM_OFF_BIT];
   assign o_dev.sleep_sel       = i_dev[LOW_PWR_BIT];
   assign o_dev.pwm_low_band    = i_dev[PWM_BAND_BIT];
   // outside clock used only with source code 3 and the enable set
   assign o_dev.use_outside_clk = (i_dev[CLK_SRC_LSB +: 2] == CLK_SRC_OUTSIDE)
                                  & i_dev[OCLK_ON_BIT];
   // codes 1 and 2 fall back to the internal oscillator but are flagged
   assign o_dev.clk_sel_bad     = (i_dev[CLK_SRC_LSB +: 2] != CLK_SRC_OUTSIDE)
                                  & (i_dev[CLK_SRC_LSB +: 2] != CLK_SRC_INTERNAL);
   assign o_dev.outside_clock_rate = i_dev[OCLK_RATE_LSB +: 3];

   // gate driver configuration a
   assign o_drv.slew                 = i_drv_a[SLEW_LSB +: 2];
   assign o_drv.ov_guard             = i_drv_a[OV_ON_BIT];
   assign o_drv.ov_20v               = i_drv_a[OV_LEVEL_BIT];
   assign o_drv.heat_warning_to_pin  = i_drv_a[HEAT_PIN_BIT];
   assign o_drv.oc_filter            = i_drv_a[OC_FILT_LSB +: 2];
   assign o_drv.oc_wait_long         = i_drv_a[OC_WAIT_BIT];
   assign o_drv.oc_level_high        = i_drv_a[OC_LEVEL_BIT];
   assign o_drv.oc_resp              = oc_resp_t'(i_drv_a[OC_RESP_LSB +: 2]);
   assign o_drv.demag_low_threshold  = i_drv_a[DEMAG_LO_BIT];
   assign o_drv.demag_high_threshold = i_drv_a[DEMAG_HI_BIT];
   assign o_drv.sync_rectify_on      = i_drv_a[SYNC_RECT_BIT];
   assign o_drv.async_rectify_on     = i_drv_a[ASYNC_RECT_BIT];
   assign o_drv.sense_amp_gain       = i_drv_a[GAIN_LSB +: 2];

   // gate driver configuration b
   assign o_drv.dcomp_on     = i_drv_b[DCOMP_ON_BIT];
   assign o_drv.dcomp_target = i_drv_b[DCOMP_TGT_LSB +: 4];
   // target code zero follows the slew setting
   assign o_drv.dcomp_auto   = (i_drv_b[DCOMP_TGT_LSB +: 4] == 4'h0);
   assign o_drv.regulator_edge_speed     = i_drv_b[REG_EDGE_BIT];
   assign o_drv.regulator_sequencing_off = i_drv_b[REG_SEQ_BIT];
   assign o_drv.regulator_current_cap    = i_drv_b[REG_CAP_BIT];
   assign o_drv.regulator_volt           = i_drv_b[REG_VOLT_LSB +: 2];
   assign o_drv.regulator_on             = ~i_drv_b[REG_OFF_BIT];
endmodule : cfg_field_decode
`default_nettype wire

// file: hw/motor_driver_config_regs.sv
// Contract
// - kick source: serial interface or gpio
// - missed kick: report only or latch
// - kick rate 10, 5, 2, 1 Hz
// - maximum input frequency field in hertz
// - bit 31 parity stored with register
// - self-test on when bit set
// - spread spectrum enabled when bit clear
// - low-power state: standby or sleep
// - pwm input band select
// - clock source code and outside enable
// - outside clock rate 8 to 1024 kHz
// - output slew rate select
// - overvoltage guard enable and level
// - heat warning shown on fault pin
// - overcurrent filter time select
// - overcurrent wait and trip level
// - overcurrent response mode
// - demag thresholds and rectification enables
// - sense amplifier gain select
// - delay compensation enable and target
// - regulator voltage select and disable
// - regulator edge, sequencing, current cap
`timescale 1ns/1ns
`default_nettype none
module motor_driver_config_regs
   import cfg_bank_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // register access from the serial interface logic
   input  wire cfg_bank_pkg::reg_req_t i_req,
   output var  logic [31:0]       o_rdata,
   output var  logic              o_rvalid,
   output var  logic              o_addr_err,
   // fault sources (raw, from other domains)
   input  wire logic [31:0]       i_bridge_flags,
   input  wire logic [31:0]       i_control_flags,
   input  wire logic              i_heat_warning,
   input  wire logic              i_other_fault,
   // decoded configuration outputs
   output var  cfg_bank_pkg::kick_cfg_t o_kick,
   output var  cfg_bank_pkg::dev_cfg_t  o_dev,
   output var  cfg_bank_pkg::drv_cfg_t  o_drv,
   // fault indicator pin, active low
   output var  logic              o_fault_indicator_pin_n
);
   // stored register images
   logic [31:0] pin_b_r;
   logic [31:0] dev_r;
   logic [31:0] drv_a_r;
   logic [31:0] drv_b_r;
   // synchronisers for status inputs
   logic [31:0] bridge_s1_r;
   logic [31:0] bridge_s2_r;
   logic [31:0] control_s1_r;
   logic [31:0] control_s2_r;
   logic [1:0]  pin_s1_r;
   logic [1:0]  pin_s2_r;
   // decoded controls from the leaf
   kick_cfg_t   kick_w;
   dev_cfg_t    dev_w;
   drv_cfg_t    drv_w;
   // read path and fault pin next value
   logic [31:0] rdata_nxt;
   logic        hit;
   logic        fault_pin_nxt;
   // next register images, chosen outside the clocked process
   logic [31:0] pin_b_nxt;
   logic [31:0] dev_nxt;
   logic [31:0] drv_a_nxt;
   logic [31:0] drv_b_nxt;

   // write merge keeps reserved bits at their reset value
   function automatic logic [31:0] merge(input logic [31:0] wd,
                                         input logic [31:0] mask,
                                         input logic [31:0] rst);
      merge = (wd & mask) | (rst & ~mask);
   endfunction : merge

   // address decode
   wire sel_pin_b = (i_req.addr == ADDR_PIN_SETUP_B);
   wire sel_dev   = (i_req.addr == ADDR_DEVICE_SETUP);
   wire sel_drv_a = (i_req.addr == ADDR_DRIVER_SETUP_A);
   wire sel_drv_b = (i_req.addr == ADDR_DRIVER_SETUP_B);
   wire sel_bflg  = (i_req.addr == ADDR_BRIDGE_FAULT_FLAGS);
   wire sel_cflg  = (i_req.addr == ADDR_CONTROL_FAULT_FLAGS);
   assign hit = sel_pin_b | sel_dev | sel_drv_a | sel_drv_b | sel_bflg | sel_cflg;

   // read mux; unmapped reads return zero
   assign rdata_nxt = sel_pin_b ? pin_b_r :
                      sel_dev   ? dev_r :
                      sel_drv_a ? drv_a_r :
                      sel_drv_b ? drv_b_r :
                      sel_bflg  ? bridge_s2_r :
                      sel_cflg  ? control_s2_r : 32'h00000000;

   // write selection; masks include bit 31 so parity travels with the contents
   // a register keeps its image unless its own address is written
   assign pin_b_nxt = !(i_req.wr & sel_pin_b) ? pin_b_r :
                      merge(i_req.wdata, WMASK_PIN_SETUP_B, RST_PIN_SETUP_B);
   assign dev_nxt   = !(i_req.wr & sel_dev) ? dev_r :
                      merge(i_req.wdata, WMASK_DEVICE_SETUP, RST_DEVICE_SETUP);
   assign drv_a_nxt = !(i_req.wr & sel_drv_a) ? drv_a_r :
                      merge(i_req.wdata, WMASK_DRIVER_SETUP_A, RST_DRIVER_SETUP_A);
   assign drv_b_nxt = !(i_req.wr & sel_drv_b) ? drv_b_r :
                      merge(i_req.wdata, WMASK_DRIVER_SETUP_B, RST_DRIVER_SETUP_B);

   // heat warning reaches the pin only when reporting enabled
   assign fault_pin_nxt = ~(pin_s2_r[1] | (pin_s2_r[0] & drv_w.heat_warning_to_pin));

   // configuration registers; parity bit stored as written, values held to reset
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pin_b_r <= RST_PIN_SETUP_B;
         dev_r   <= RST_DEVICE_SETUP;
         drv_a_r <= RST_DRIVER_SETUP_A;
         drv_b_r <= RST_DRIVER_SETUP_B;
      end
      else
      begin
         // images held until the next write or reset
         pin_b_r <= pin_b_nxt;
         dev_r   <= dev_nxt;
         drv_a_r <= drv_a_nxt;
         drv_b_r <= drv_b_nxt;
      end
   end

   // two-stage synchronisers for outside status
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         bridge_s1_r  <= 32'h00000000;
         bridge_s2_r  <= 32'h00000000;
         control_s1_r <= 32'h00000000;
         control_s2_r <= 32'h00000000;
         pin_s1_r     <= 2'h0;
         pin_s2_r     <= 2'h0;
      end
      else
      begin
         bridge_s1_r  <= i_bridge_flags;
         bridge_s2_r  <= bridge_s1_r;
         control_s1_r <= i_control_flags;
         control_s2_r <= control_s1_r;
         pin_s1_r     <= {i_other_fault, i_heat_warning};
         pin_s2_r     <= pin_s1_r;
      end
   end

   // read answer one cycle after request
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_rdata    <= 32'h00000000;
         o_rvalid   <= 1'b0;
         o_addr_err <= 1'b0;
      end
      else
      begin
         o_rdata    <= i_req.rd ? rdata_nxt : 32'h00000000;
         o_rvalid   <= i_req.rd;
         o_addr_err <= (i_req.rd | i_req.wr) & ~hit;
      end
   end

   // registered control outputs
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_kick <= '0;
         o_dev  <= '0;
         o_drv  <= '0;
         o_fault_indicator_pin_n <= 1'b1;
      end
      else
      begin
         o_kick <= kick_w;
         o_dev  <= dev_w;
         o_drv  <= drv_w;
         o_fault_indicator_pin_n <= fault_pin_nxt;
      end
   end

   // field decoding
   cfg_field_decode u_decode (
      .i_pin_b (pin_b_r),
      .i_dev   (dev_r),
      .i_drv_a (drv_a_r),
      .i_drv_b (drv_b_r),
      .o_kick  (kick_w),
      .o_dev   (dev_w),
      .o_drv   (drv_w)
   );
endmodule : motor_driver_config_regs
`default_nettype wire

// file: test/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model
   import cfg_bank_pkg::*;
(
   // bench side
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic        i_wr,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   // request toward the bank
   output var  cfg_bank_pkg::reg_req_t o_req
);
   initial o_req = '0;
   // one-cycle request; idle lines are scrambled so the bank cannot lean on stale data
   always @(posedge i_clk)
   begin
      if (i_go)
         o_req <= '{wr: i_wr, rd: !i_wr, addr: i_addr, wdata: i_wdata};
      else
         o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~o_req.addr, wdata: ~o_req.wdata};
   end
endmodule : host_model
`default_nettype wire

// file: test/cfg_bank_props.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_bank_props
   import cfg_bank_pkg::*;
(
   // watched ports
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   input wire cfg_bank_pkg::reg_req_t  i_req,
   input wire logic [31:0]             o_rdata,
   input wire logic                    o_rvalid,
   input wire logic                    o_addr_err,
   input wire logic                    i_other_fault,
   input wire cfg_bank_pkg::kick_cfg_t o_kick,
   input wire cfg_bank_pkg::dev_cfg_t  o_dev,
   input wire cfg_bank_pkg::drv_cfg_t  o_drv,
   input wire logic                    o_fault_indicator_pin_n
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // address decode of the incoming request
   wire logic mapped = i_req.addr inside {ADDR_PIN_SETUP_B, ADDR_DEVICE_SETUP,
      ADDR_DRIVER_SETUP_A, ADDR_DRIVER_SETUP_B, ADDR_BRIDGE_FAULT_FLAGS, ADDR_CONTROL_FAULT_FLAGS};
   wire logic wr_a6 = i_req.wr && i_req.addr == ADDR_PIN_SETUP_B;
   wire logic wr_a8 = i_req.wr && i_req.addr == ADDR_DEVICE_SETUP;
   wire logic wr_ac = i_req.wr && i_req.addr == ADDR_DRIVER_SETUP_A;
   wire logic wr_ae = i_req.wr && i_req.addr == ADDR_DRIVER_SETUP_B;

   chk_read_answer: assert property (i_req.rd && mapped |=> o_rvalid)
      else $error("read got no answer");
   chk_rvalid_cause: assert property (o_rvalid |->
      $past(i_req.rd) && (o_addr_err == !$past(mapped)))
      else $error("answer without read or wrong error flag");
   chk_rdata_quiet: assert property (!o_rvalid |-> o_rdata == 32'h00000000)
      else $error("read data not zero while idle");
   chk_unmapped_err: assert property ((i_req.rd || i_req.wr) && !mapped |=> o_addr_err)
      else $error("unmapped access not flagged");
   chk_kick_follow: assert property (wr_a6 |-> ##2
      o_kick == $past(i_req.wdata[16:13], 2))
      else $error("watchdog controls wrong");
   chk_spread_inv: assert property (wr_a8 |-> ##2
      o_dev.spread_on == !$past(i_req.wdata[14], 2))
      else $error("spread sense wrong");
   chk_gain_follow: assert property (wr_ac |-> ##2
      o_drv.sense_amp_gain == $past(i_req.wdata[1:0], 2))
      else $error("gain field wrong");
   chk_regulator_off: assert property (wr_ae |-> ##2
      o_drv.regulator_on == !$past(i_req.wdata[20], 2))
      else $error("regulator enable wrong");
   chk_fault_pin: assert property (i_other_fault [*5] |-> !o_fault_indicator_pin_n)
      else $error("fault pin not low");

   // main scenarios reached
   cov_drv_write: cover property (wr_ac ##2 o_drv.oc_resp == OC_IGNORE);
   cov_addr_err: cover property (o_addr_err);
   cov_bad_read: cover property (o_rvalid && o_addr_err);
   cov_pin_low: cover property (!o_fault_indicator_pin_n);
endmodule : cfg_bank_props

bind motor_driver_config_regs cfg_bank_props u_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_addr_err(o_addr_err),
   .i_other_fault(i_other_fault), .o_kick(o_kick), .o_dev(o_dev), .o_drv(o_drv),
   .o_fault_indicator_pin_n(o_fault_indicator_pin_n));
`default_nettype wire

// file: test/motor_driver_config_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module motor_driver_config_regs_tb;
   import cfg_bank_pkg::*;
   logic        i_clk = 1'b0;    // 10 MHz
   logic        i_rst = 1'b1;    // sync reset
   logic        go = 1'b0;       // host request strobe
   logic        wr = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wd = 32'h00000000;
   logic [31:0] bflags = 32'h00000000;
   logic [31:0] cflags = 32'h00000000;
   logic        heat = 1'b0;
   logic        other = 1'b0;
   reg_req_t    req;
   logic [31:0] rdata;
   logic        rvalid, aerr, pin_n;
   kick_cfg_t   kick;
   dev_cfg_t    dev;
   drv_cfg_t    drv;
   int          err_total = 0;
   int          num_checks = 0;
   int          seed = 51;
   int          k;
   logic [31:0] d;
   logic [31:0] img [4];   // expected images of A6, A8, AC, AE
   logic [7:0]  amap [4] = '{ADDR_PIN_SETUP_B, ADDR_DEVICE_SETUP, ADDR_DRIVER_SETUP_A,
                             ADDR_DRIVER_SETUP_B};
   logic [31:0] wmask [4] = '{WMASK_PIN_SETUP_B, WMASK_DEVICE_SETUP, WMASK_DRIVER_SETUP_A,
                              WMASK_DRIVER_SETUP_B};
   logic [31:0] rstv [4] = '{RST_PIN_SETUP_B, RST_DEVICE_SETUP, RST_DRIVER_SETUP_A,
                             RST_DRIVER_SETUP_B};

   host_model u_host (.i_clk(i_clk), .i_go(go), .i_wr(wr), .i_addr(addr), .i_wdata(wd),
      .o_req(req));
   motor_driver_config_regs DUT (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .o_rdata(rdata),
      .o_rvalid(rvalid), .o_addr_err(aerr), .i_bridge_flags(bflags), .i_control_flags(cflags),
      .i_heat_warning(heat), .i_other_fault(other), .o_kick(kick), .o_dev(dev), .o_drv(drv),
      .o_fault_indicator_pin_n(pin_n));

   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   // expected decode of the device image
   function automatic dev_cfg_t dev_exp(logic [31:0] e);
      return '{e[30:16], e[15], !e[14], e[11], e[10], e[9:8] == 2'h3 && e[6],
               e[9:8] == 2'h1 || e[9:8] == 2'h2, e[5:3]};
   endfunction : dev_exp

   // expected decode of both driver images
   function automatic drv_cfg_t drv_exp(logic [31:0] a, logic [31:0] b);
      return '{a[27:26], a[18], a[19], a[16], a[13:12], a[11], a[10], oc_resp_t'(a[9:8]),
               a[5], a[4], a[3], a[2], a[1:0], b[30], b[29:26] == 4'h0, b[29:26], b[25],
               b[24], b[23], b[22:21], !b[20]};
   endfunction : drv_exp

   task automatic chk(logic [63:0] seen, logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk

   // one access; returns where the answer is visible
   task automatic acc(logic w, logic [7:0] a, logic [31:0] dat);
      go = 1'b1;
      wr = w;
      addr = a;
      wd = dat;
      @(posedge i_clk) #1;
      go = 1'b0;
      @(posedge i_clk) #1;
   endtask : acc

   task automatic rd(logic [7:0] a, logic [31:0] e);
      acc(1'b0, a, 32'h00000000);
      chk({rvalid, rdata}, {1'b1, e});
   endtask : rd

   task automatic end_sim;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim

   // hang guard, far beyond the few hundred cycles needed
   initial
   begin
      #500000;
      err_total++;
      end_sim();
   end

   initial
   begin
      repeat (5) @(posedge i_clk);
      #1 i_rst = 1'b0;
      repeat (2) @(posedge i_clk) #1;
      for (int i = 0; i < 4; i++) img[i] = rstv[i];
      chk(kick, kick_cfg_t'(img[0][16:13]));
      chk(dev, dev_exp(img[1]));
      chk(drv, drv_exp(img[2], img[3]));
      for (int i = 0; i < 4; i++) rd(amap[i], img[i]);
      // corner patterns first, then random words; every clock and overcurrent code visited
      for (int n = 0; n < 40; n++)
      begin
         k = n % 4;
         d = (n < 4) ? 32'hFFFFFFFF : (n < 8) ? 32'h00000000 : $random(seed);
         if (k inside {1, 2}) d[9:8] = n[3:2];
         acc(1'b1, amap[k], d);
         img[k] = (d & wmask[k]) | (rstv[k] & ~wmask[k]);
         @(posedge i_clk) #1;
         chk(kick, kick_cfg_t'(img[0][16:13]));
         chk(dev, dev_exp(img[1]));
         chk(drv, drv_exp(img[2], img[3]));
         rd(amap[k], img[k]);
      end
      // unmapped place and read-only mirrors
      bflags = $random(seed);
      cflags = $random(seed);
      acc(1'b1, 8'hA4, 32'hFFFFFFFF);
      chk(aerr, 1'b1);
      acc(1'b0, 8'hA4, 32'h00000000);
      chk({aerr, rdata}, {1'b1, 32'h00000000});
      acc(1'b1, ADDR_BRIDGE_FAULT_FLAGS, ~bflags);
      chk(aerr, 1'b0);
      rd(ADDR_BRIDGE_FAULT_FLAGS, bflags);
      rd(ADDR_CONTROL_FAULT_FLAGS, cflags);
      for (int i = 0; i < 4; i++) rd(amap[i], img[i]);
      // fault pin from other faults and from gated heat warnings
      other = 1'b1;
      repeat (5) @(posedge i_clk) #1;
      chk(pin_n, 1'b0);
      other = 1'b0;
      heat = 1'b1;
      for (int h = 0; h < 2; h++)
      begin
         acc(1'b1, ADDR_DRIVER_SETUP_A, h ? 32'h00010000 : 32'h00000000);
         repeat (5) @(posedge i_clk) #1;
         chk(pin_n, !h[0]);
      end
      // a second reset brings back the reset images
      i_rst = 1'b1;
      repeat (5) @(posedge i_clk) #1;
      i_rst = 1'b0;
      repeat (2) @(posedge i_clk) #1;
      chk(drv, drv_exp(rstv[2], rstv[3]));
      for (int i = 0; i < 4; i++) rd(amap[i], rstv[i]);
      end_sim();
   end
endmodule : motor_driver_config_regs_tb
`default_nettype wire
